// ---- cod_regs.svh ----
// Opcodes, cycle counts and reset values for the opcode decoder
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

`define COD_OP_TEST_DIR     8'h3d
`define COD_OP_TEST_ACC     8'h4d
`define COD_OP_TEST_IDX     8'h5d
`define COD_OP_TEST_BOFS    8'h6d
`define COD_OP_TEST_PTR     8'h7d
`define COD_OP_WAIT         8'h8f
`define COD_OP_MOVE_INDEX   8'h9f

`define COD_CYC_TEST_DIR    4'h4
`define COD_CYC_TEST_ACC    4'h3
`define COD_CYC_TEST_IDX    4'h3
`define COD_CYC_TEST_BOFS   4'h5
`define COD_CYC_TEST_PTR    4'h4
`define COD_CYC_WAIT        4'h2
`define COD_CYC_MOVE_INDEX  4'h2

`define COD_PC_RESET    16'h0000
`define COD_ACC_RESET   8'h00
`define COD_IDX_RESET   8'h00
`define COD_FLAGS_RESET 5'h08

`endif

// ---- cod_pkg.sv ----
// Types shared by the opcode decoder
package cod_pkg;

  typedef enum logic [5:0] {
    COD_FETCH = 6'h01,
    COD_OPND1 = 6'h02,
    COD_OPND2 = 6'h04,
    COD_EXEC  = 6'h08,
    COD_PAD   = 6'h10,
    COD_HALT  = 6'h20
  } cod_state_type;

  typedef enum logic [8:0] {
    COD_BIT_BRANCH               = 9'h001,
    COD_DIRECT                   = 9'h002,
    COD_PC_OFFSET_BRANCH_MODE    = 9'h004,
    COD_IMPLIED_OPERAND_MODE     = 9'h008,
    COD_POINTER_BYTE_OFFSET_MODE = 9'h010,
    COD_OFFSETLESS_POINTER_MODE  = 9'h020,
    COD_LITERAL_OPERAND_MODE     = 9'h040,
    COD_FULL_ADDRESS             = 9'h080,
    COD_POINTER_WORD_OFFSET_MODE = 9'h100
  } cod_mode_type;

  // Flag register layout, high to low
  typedef struct packed {
    logic half;
    logic irq_mask;
    logic neg;
    logic zero;
    logic carry;
  } cod_flags_type;

endpackage : cod_pkg

// ---- cod_decode.sv ----
// Opcode decoder and sequencer for the test, transfer and wait tail of the CPU
// Function
// [RQ1] The test opcodes 3D/4D/5D/6D/7D set N and Z from operand minus zero in 4/3/3/5/4 cycles.
// [RQ2] Opcode 9F copies the index into the accumulator, keeps all flags and takes 2 cycles.
// [RQ3] Opcode 8F clears the interrupt mask, halts until an interrupt and counts as 2 cycles.
// [RQ4] Byte-offset pointer mode fetches one offset byte and adds the index to it.
// [RQ5] Word-offset pointer mode fetches high then low offset byte and adds the index.
// [RQ6] Full-address mode takes the address as high byte then low byte after the opcode.
// [RQ7] Bit-test-and-branch reads a page-zero address byte then a branch offset off the PC.
// [RQ8] The upper opcode nibble picks the mode and class, the lower one the operation.
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.svh"
module cod_decode
  import cod_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic [7:0]    prog_data,
  input  wire logic [7:0]    data_in,
  input  wire logic          irq_req,
  output logic      [15:0]   prog_addr,
  output logic      [15:0]   data_addr,
  output logic      [7:0]    acc_out,
  output logic      [7:0]    idx_out,
  output cod_flags_type      flag_register,
  output logic      [15:0]   branch_target,
  output logic               addr_valid,
  output logic               instr_done,
  output logic               halted
);

  // Mode and class from the upper nibble
  function automatic cod_mode_type mode_of(input logic [3:0] hi);
    case (hi) // RQ8
      4'h0:    mode_of = COD_BIT_BRANCH;
      4'h1:    mode_of = COD_DIRECT;
      4'h2:    mode_of = COD_PC_OFFSET_BRANCH_MODE;
      4'h3:    mode_of = COD_DIRECT;
      4'h6:    mode_of = COD_POINTER_BYTE_OFFSET_MODE;
      4'h7:    mode_of = COD_OFFSETLESS_POINTER_MODE;
      4'ha:    mode_of = COD_LITERAL_OPERAND_MODE;
      4'hb:    mode_of = COD_DIRECT;
      4'hc:    mode_of = COD_FULL_ADDRESS;
      4'hd:    mode_of = COD_POINTER_WORD_OFFSET_MODE;
      4'he:    mode_of = COD_POINTER_BYTE_OFFSET_MODE;
      4'hf:    mode_of = COD_OFFSETLESS_POINTER_MODE;
      default: mode_of = COD_IMPLIED_OPERAND_MODE;
    endcase
  endfunction : mode_of

  // Operand bytes that follow the opcode
  function automatic logic [1:0] opnd_bytes(input cod_mode_type m);
    case (m)
      COD_BIT_BRANCH, COD_FULL_ADDRESS, COD_POINTER_WORD_OFFSET_MODE: opnd_bytes = 2'd2;
      COD_IMPLIED_OPERAND_MODE, COD_OFFSETLESS_POINTER_MODE:          opnd_bytes = 2'd0;
      default:                                                         opnd_bytes = 2'd1;
    endcase
  endfunction : opnd_bytes

  // Total cycles of an instruction
  function automatic logic [3:0] cycles_of(input logic [7:0] op);
    case (op)
      `COD_OP_TEST_DIR:   cycles_of = `COD_CYC_TEST_DIR; // RQ1
      `COD_OP_TEST_ACC:   cycles_of = `COD_CYC_TEST_ACC;
      `COD_OP_TEST_IDX:   cycles_of = `COD_CYC_TEST_IDX;
      `COD_OP_TEST_BOFS:  cycles_of = `COD_CYC_TEST_BOFS;
      `COD_OP_TEST_PTR:   cycles_of = `COD_CYC_TEST_PTR;
      `COD_OP_MOVE_INDEX: cycles_of = `COD_CYC_MOVE_INDEX; // RQ2
      `COD_OP_WAIT:       cycles_of = `COD_CYC_WAIT; // RQ3
      default:         cycles_of = 4'h2 + {2'b00, opnd_bytes(mode_of(op[7:4]))};
    endcase
  endfunction : cycles_of

  // Test opcodes share the low nibble D over columns 3..7
  function automatic logic is_test(input logic [7:0] op);
    is_test = (op[3:0] == 4'hd) && (op[7:4] >= 4'h3) && (op[7:4] <= 4'h7);
  endfunction : is_test

  cod_state_type state_reg, state_next;
  cod_mode_type  mode_reg, mode_next;
  cod_flags_type flags_reg, flags_next;
  logic [7:0]    op_reg, op_next;
  logic [7:0]    byte1_reg, byte1_next;
  logic [7:0]    acc_reg, acc_next;
  logic [7:0]    idx_reg, idx_next;
  logic [15:0]   pc_reg, pc_next;
  logic [15:0]   ea_reg, ea_next;
  logic [15:0]   tgt_reg, tgt_next;
  logic [3:0]    cnt_reg, cnt_next;
  logic          valid_reg, valid_next;
  logic          done_reg, done_next;
  logic [7:0]    probe_val;
  logic          last_cycle;

  assign last_cycle = (state_reg == COD_EXEC || state_reg == COD_PAD) && (cnt_reg == 4'h0);

  // Operand seen by the test opcodes
  always_comb begin
    case (op_reg[7:4])
      4'h4:    probe_val = acc_reg;
      4'h5:    probe_val = idx_reg;
      default: probe_val = data_in;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    flags_next = flags_reg;
    op_next    = op_reg;
    byte1_next = byte1_reg;
    acc_next   = acc_reg;
    idx_next   = idx_reg;
    pc_next    = pc_reg;
    ea_next    = ea_reg;
    tgt_next   = tgt_reg;
    cnt_next   = (cnt_reg == 4'h0) ? 4'h0 : cnt_reg - 4'h1;
    valid_next = 1'b0;
    done_next  = 1'b0;
    case (state_reg)
      COD_FETCH: begin
        op_next   = prog_data;
        mode_next = mode_of(prog_data[7:4]); // RQ8
        pc_next   = pc_reg + 16'h0001;
        cnt_next  = cycles_of(prog_data) - 4'h2; // Fetch and last cycle not counted
        ea_next   = {8'h00, idx_reg};
        state_next = (opnd_bytes(mode_of(prog_data[7:4])) == 2'd0) ? COD_EXEC : COD_OPND1;
      end
      COD_OPND1: begin
        byte1_next = prog_data;
        pc_next    = pc_reg + 16'h0001;
        state_next = (opnd_bytes(mode_reg) == 2'd2) ? COD_OPND2 : COD_EXEC;
        case (mode_reg)
          COD_POINTER_BYTE_OFFSET_MODE: ea_next = {8'h00, prog_data} + {8'h00, idx_reg}; // RQ4
          COD_PC_OFFSET_BRANCH_MODE: tgt_next = pc_reg + 16'h0001 + {{8{prog_data[7]}}, prog_data};
          default:                      ea_next = {8'h00, prog_data}; // RQ7
        endcase
      end
      COD_OPND2: begin
        pc_next    = pc_reg + 16'h0001;
        state_next = COD_EXEC;
        case (mode_reg)
          COD_POINTER_WORD_OFFSET_MODE: ea_next = {byte1_reg, prog_data} + {8'h00, idx_reg}; // RQ5
          COD_FULL_ADDRESS:             ea_next = {byte1_reg, prog_data}; // RQ6
          default: tgt_next = pc_reg + 16'h0001 + {{8{prog_data[7]}}, prog_data}; // RQ7
        endcase
      end
      COD_EXEC: begin
        if (is_test(op_reg)) begin
          flags_next.neg  = probe_val[7]; // RQ1
          flags_next.zero = (probe_val == 8'h00); // RQ1
        end else if (op_reg == `COD_OP_MOVE_INDEX) begin
          acc_next = idx_reg; // RQ2
        end else if (op_reg == `COD_OP_WAIT) begin
          flags_next.irq_mask = 1'b0; // RQ3
        end else begin
          valid_next = 1'b1;
        end
        done_next = (cnt_reg == 4'h0);
        if (op_reg == `COD_OP_WAIT) begin
          state_next = COD_HALT; // RQ3
        end else begin
          state_next = (cnt_reg == 4'h0) ? COD_FETCH : COD_PAD;
        end
      end
      COD_PAD: begin
        if (cnt_reg == 4'h0) begin
          done_next  = 1'b1;
          state_next = COD_FETCH;
        end
      end
      COD_HALT: begin
        if (irq_req) begin
          state_next = COD_FETCH; // RQ3
        end
      end
      default: state_next = COD_FETCH;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= COD_FETCH;
      mode_reg  <= COD_IMPLIED_OPERAND_MODE;
      flags_reg <= `COD_FLAGS_RESET;
      op_reg    <= 8'h00;
      byte1_reg <= 8'h00;
      acc_reg   <= `COD_ACC_RESET;
      idx_reg   <= `COD_IDX_RESET;
      pc_reg    <= `COD_PC_RESET;
      ea_reg    <= 16'h0000;
      tgt_reg   <= 16'h0000;
      cnt_reg   <= 4'h0;
      valid_reg <= 1'b0;
      done_reg  <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      flags_reg <= flags_next;
      op_reg    <= op_next;
      byte1_reg <= byte1_next;
      acc_reg   <= acc_next;
      idx_reg   <= idx_next;
      pc_reg    <= pc_next;
      ea_reg    <= ea_next;
      tgt_reg   <= tgt_next;
      cnt_reg   <= cnt_next;
      valid_reg <= valid_next;
      done_reg  <= done_next;
    end
  end

  // Outputs straight from flops, except halted, decoded from the state register
  assign prog_addr     = pc_reg;
  assign data_addr     = ea_reg;
  assign acc_out       = acc_reg;
  assign idx_out       = idx_reg;
  assign flag_register = flags_reg;
  assign branch_target = tgt_reg;
  assign addr_valid    = valid_reg;
  assign instr_done    = done_reg;
  assign halted        = (state_reg == COD_HALT);

  // Checks, suspended while the clock enable is low
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !clk_en);

  property p_test_acc_flags;
    (state_reg == COD_EXEC && op_reg == `COD_OP_TEST_ACC) |=>
      flags_reg.neg == $past(acc_reg[7]) && flags_reg.zero == ($past(acc_reg) == 8'h00)
      && flags_reg.carry == $past(flags_reg.carry) && flags_reg.half == $past(flags_reg.half);
  endproperty
  a_test_acc_flags: assert property (p_test_acc_flags) else $error("test flags wrong"); // RQ1

  property p_dir_cycles;
    (state_reg == COD_FETCH && prog_data == `COD_OP_TEST_DIR) |-> !last_cycle [*3] ##1 last_cycle;
  endproperty
  a_dir_cycles: assert property (p_dir_cycles) else $error("test dir not 4 cycles"); // RQ1

  property p_bofs_cycles;
    (state_reg == COD_FETCH && prog_data == `COD_OP_TEST_BOFS) |-> ##4 last_cycle;
  endproperty
  a_bofs_cycles: assert property (p_bofs_cycles) else $error("offset test length"); // RQ1

  property p_move_index;
    (state_reg == COD_FETCH && prog_data == `COD_OP_MOVE_INDEX) |-> ##1 last_cycle ##1
      (acc_reg == $past(idx_reg) && flags_reg == $past(flags_reg, 2));
  endproperty
  a_move_index: assert property (p_move_index) else $error("index transfer wrong"); // RQ2

  property p_wait;
    (state_reg == COD_EXEC && op_reg == `COD_OP_WAIT) |=>
      halted && !flags_reg.irq_mask && flags_reg.neg == $past(flags_reg.neg);
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not halt"); // RQ3

  property p_halt_hold;
    (halted && !irq_req) |=> halted;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("left halt without interrupt"); // RQ3

  property p_bofs_addr;
    (state_reg == COD_OPND1 && mode_reg == COD_POINTER_BYTE_OFFSET_MODE) |=>
      data_addr == {8'h00, $past(prog_data)} + {8'h00, $past(idx_reg)};
  endproperty
  a_bofs_addr: assert property (p_bofs_addr) else $error("byte offset address wrong"); // RQ4

  property p_wofs_addr;
    (state_reg == COD_OPND1 && mode_reg == COD_POINTER_WORD_OFFSET_MODE) ##1 1'b1 |=>
      data_addr == {$past(prog_data, 2), $past(prog_data)} + {8'h00, $past(idx_reg)};
  endproperty
  a_wofs_addr: assert property (p_wofs_addr) else $error("word offset address wrong"); // RQ5

  property p_ext_addr;
    (state_reg == COD_OPND1 && mode_reg == COD_FULL_ADDRESS) ##1 1'b1 |=>
      data_addr == {$past(prog_data, 2), $past(prog_data)};
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("full address wrong"); // RQ6

  property p_bit_branch;
    (state_reg == COD_OPND1 && mode_reg == COD_BIT_BRANCH) ##1 1'b1 |=>
      data_addr == {8'h00, $past(prog_data, 2)} &&
      branch_target == pc_reg + {{8{$past(prog_data[7])}}, $past(prog_data)};
  endproperty
  a_bit_branch: assert property (p_bit_branch) else $error("bit branch target wrong"); // RQ7

  property p_mode_map;
    (state_reg == COD_FETCH && prog_data[7:4] == 4'hd) |=>
      mode_reg == COD_POINTER_WORD_OFFSET_MODE;
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode decode wrong"); // RQ8

  c_test_bofs: cover property (state_reg == COD_EXEC && op_reg == `COD_OP_TEST_BOFS);
  c_wait_wake: cover property (halted && irq_req);
  c_bit_branch: cover property (state_reg == COD_EXEC && mode_reg == COD_BIT_BRANCH);
endmodule : cod_decode
`default_nettype wire

// ---- cod_prog_mem.sv ----
// Program and data memory model facing the opcode decoder
`timescale 1ns/1ps
`default_nettype none

module cod_prog_mem (
  input  wire logic [15:0] prog_addr,
  input  wire logic [15:0] data_addr,
  output logic      [7:0]  prog_data,
  output logic      [7:0]  data_in
);
  logic [7:0] prog_mem [256];
  logic [7:0] data_mem [256];

  // Unloaded places answer the inverted low address byte
  initial begin
    for (int i = 0; i < 256; i++) begin
      prog_mem[i] = ~i[7:0];
      data_mem[i] = ~i[7:0];
    end
  end

  // Same-cycle read; outside page zero the pattern keeps moving
  assign prog_data = (prog_addr[15:8] == 8'h00) ? prog_mem[prog_addr[7:0]] : ~prog_addr[7:0];
  assign data_in   = (data_addr[15:8] == 8'h00) ? data_mem[data_addr[7:0]] : ~data_addr[7:0];
endmodule : cod_prog_mem

`default_nettype wire

// ---- cod_decode_tb.sv ----
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`include "cod_regs.svh"

module cod_decode_tb import cod_pkg::*; ();
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic          clk_en = 1'b1;
  logic          irq_req = 1'b0;
  logic [7:0]    prog_data;
  logic [7:0]    data_in;
  logic [7:0]    acc_out;
  logic [7:0]    idx_out;
  logic [15:0]   prog_addr;
  logic [15:0]   data_addr;
  logic [15:0]   branch_target;
  logic          addr_valid;
  logic          instr_done;
  logic          halted;
  logic          saw_av;
  cod_flags_type flag_register;
  cod_flags_type exp_f;
  int            mismatches = 0;
  int            checks_done = 0;
  int            n_cyc;

  // Clock of 5 ns
  always #2.5 ref_clk = ~ref_clk;

  cod_decode u_cod_decode (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .prog_data(prog_data), .data_in(data_in), .irq_req(irq_req),
    .prog_addr(prog_addr), .data_addr(data_addr), .acc_out(acc_out),
    .idx_out(idx_out), .flag_register(flag_register),
    .branch_target(branch_target), .addr_valid(addr_valid),
    .instr_done(instr_done), .halted(halted));

  cod_prog_mem u_cod_prog_mem (.prog_addr(prog_addr), .data_addr(data_addr),
    .prog_data(prog_data), .data_in(data_in));

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic fail(input string msg);
    mismatches++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask : chk_word

  task automatic chk_flags(input cod_flags_type got, input cod_flags_type exp, input string msg);
    checks_done++;
    if (got !== exp) fail(msg);
  endtask : chk_flags

  task automatic chk_count(input int got, input int exp, input string msg);
    checks_done++;
    if (got != exp) fail(msg);
  endtask : chk_count

  // Bounded wait for the completion pulse, counting cycles
  task automatic wait_done();
    n_cyc = 0;
    saw_av = 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
      n_cyc++;
      saw_av = saw_av | addr_valid;
    end while (instr_done !== 1'b1 && n_cyc < 20);
    if (instr_done !== 1'b1) begin
      fail("no completion pulse");
      summarize();
    end
  endtask : wait_done

  task automatic run_instr(input int cyc, input logic av, input string msg);
    wait_done();
    chk_count(n_cyc, cyc, msg);
    chk_bit(saw_av, av, "address pulse");
  endtask : run_instr

  // Load memory, hold reset, check reset state
  task automatic scn_reset();
    logic [7:0] img [23] = '{`COD_OP_MOVE_INDEX, `COD_OP_TEST_DIR, 8'h10, `COD_OP_TEST_ACC,
      `COD_OP_TEST_IDX, `COD_OP_TEST_BOFS, 8'h20, `COD_OP_TEST_PTR, `COD_OP_MOVE_INDEX,
      8'hc6, 8'h12, 8'h34, 8'hd6, 8'h01, 8'h02, 8'h00, 8'h30, 8'h05, 8'h20, 8'hfe,
      `COD_OP_WAIT, `COD_OP_TEST_DIR, 8'h40};
    @(posedge ref_clk);
    for (int i = 0; i < 23; i++) u_cod_prog_mem.prog_mem[i] = img[i];
    u_cod_prog_mem.data_mem[8'h10] = 8'h80;
    u_cod_prog_mem.data_mem[8'h20] = 8'hff;
    u_cod_prog_mem.data_mem[8'h00] = 8'h01;
    u_cod_prog_mem.data_mem[8'h40] = 8'h00;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_word(prog_addr, `COD_PC_RESET, "reset pc");
    chk_word({8'h00, acc_out}, {8'h00, `COD_ACC_RESET}, "reset acc");
    chk_word({8'h00, idx_out}, {8'h00, `COD_IDX_RESET}, "reset index");
    chk_flags(flag_register, `COD_FLAGS_RESET, "reset flags");
    chk_bit(halted, 1'b0, "reset halted");
  endtask : scn_reset

  // Released with the enable low: nothing may advance
  task automatic scn_freeze();
    @(posedge ref_clk);
    rst <= 1'b0;
    clk_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_word(prog_addr, `COD_PC_RESET, "frozen pc");
    chk_bit(instr_done, 1'b0, "frozen done");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_done();
    exp_f = `COD_FLAGS_RESET;
    chk_flags(flag_register, exp_f, "transfer flags");
  endtask : scn_freeze

  // All five test forms: length and flags; operand address for the three memory forms only
  task automatic scn_test_ops();
    int          cyc [5] = '{`COD_CYC_TEST_DIR, `COD_CYC_TEST_ACC, `COD_CYC_TEST_IDX,
                             `COD_CYC_TEST_BOFS, `COD_CYC_TEST_PTR};
    logic [1:0]  nz [5] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h0};
    logic [15:0] da [5] = '{16'h0010, 16'h0000, 16'h0000, 16'h0020, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      run_instr(cyc[i], 1'b0, "test length");
      exp_f.neg = nz[i][1];
      exp_f.zero = nz[i][0];
      chk_flags(flag_register, exp_f, "test flags");
      if (i != 1 && i != 2) chk_word(data_addr, da[i], "test address");
    end
  endtask : scn_test_ops

  // Index to accumulator, flags kept
  task automatic scn_transfer();
    run_instr(`COD_CYC_MOVE_INDEX, 1'b0, "transfer length");
    chk_word({8'h00, acc_out}, {8'h00, `COD_IDX_RESET}, "transfer value");
    chk_flags(flag_register, exp_f, "transfer flags");
  endtask : scn_transfer

  // Full address, word offset, bit-branch and relative operand layouts
  task automatic scn_modes();
    run_instr(4, 1'b1, "full address length");
    chk_word(data_addr, 16'h1234, "full address");
    run_instr(4, 1'b1, "word offset length");
    chk_word(data_addr, 16'h0102, "word offset address");
    run_instr(4, 1'b1, "bit branch length");
    chk_word(data_addr, 16'h0030, "bit branch address");
    chk_word(branch_target, 16'h0017, "bit branch target");
    run_instr(3, 1'b1, "relative length");
    chk_word(branch_target, 16'h0012, "relative target");
    chk_flags(flag_register, exp_f, "mode flags");
  endtask : scn_modes

  // Wait: mask cleared, halt held, wake on request
  task automatic scn_wait();
    logic [15:0] pc_hold;
    int          k;
    run_instr(`COD_CYC_WAIT, 1'b0, "wait length");
    for (k = 0; k < 6 && halted !== 1'b1; k++) @(posedge ref_clk) #1;
    chk_bit(halted, 1'b1, "not halted");
    if (halted !== 1'b1) summarize();
    exp_f.irq_mask = 1'b0;
    chk_flags(flag_register, exp_f, "wait flags");
    pc_hold = prog_addr;
    repeat (10) @(posedge ref_clk);
    #1;
    chk_bit(halted, 1'b1, "halt left early");
    chk_word(prog_addr, pc_hold, "pc moved in halt");
    @(posedge ref_clk);
    irq_req <= 1'b1;
    for (k = 0; k < 6 && halted !== 1'b0; k++) @(posedge ref_clk) #1;
    chk_bit(halted, 1'b0, "no wake");
    if (halted !== 1'b0) summarize();
    @(posedge ref_clk);
    irq_req <= 1'b0;
    wait_done();
    exp_f.zero = 1'b1;
    chk_flags(flag_register, exp_f, "after wake flags");
    chk_word(data_addr, 16'h0040, "after wake address");
  endtask : scn_wait

  // Main sequence
  initial begin
    scn_reset();
    scn_freeze();
    scn_test_ops();
    scn_transfer();
    scn_modes();
    scn_wait();
    summarize();
  end
endmodule : cod_decode_tb

`default_nettype wire
